//--- verilog/mode_reg_pkg.sv
// Behaviour
// - select code on bank group 0 and bank address picks register; 100 fourth, 101 fifth.
// - select code 111 on a mode register set command is ignored: no state change, no response.
// - writes to unsupported feature bits are discarded; features stay disabled.
// - fourth register bit A10 stores and drives read preamble training mode.
// - fourth register bit A4 enables the internal reference voltage monitor.
// - fifth register A8:A6 selects park termination, 000 off, others resistor fractions.
// - fifth register A5 set deactivates termination input buffer in power-down.
// - vendor page holds four 8-bit read/write locations picked by bank address.
// - page access needs third register A2 set and A1:A0 equal to 11.
package mode_reg_pkg;
   localparam logic [2:0] SEL_PAGE_ACCESS = 3'h3;
   localparam logic [2:0] SEL_PREAMBLE    = 3'h4;
   localparam logic [2:0] SEL_TERMINATION = 3'h5;
   localparam logic [2:0] SEL_CONTROL_WORD = 3'h7;
   localparam int         BIT_TRAINING   = 10;
   localparam int         BIT_MONITOR    = 4;
   localparam int         BIT_DATA_MASK  = 10;
   localparam int         PARK_MSB       = 8;
   localparam int         PARK_LSB       = 6;
   localparam int         BIT_BUF_OFF    = 5;
   localparam int         BIT_PAGE_EN    = 2;
   localparam logic [1:0] PAGE_VENDOR    = 2'h3;
   localparam int         PAGE_LOCS      = 4;
   localparam logic [7:0] VENDOR_RESET   = 8'h00;
   localparam logic [2:0] PARK_RESET     = 3'h0;
endpackage : mode_reg_pkg

//--- verilog/vendor_loc.sv
`timescale 1ns/10ps
module vendor_loc #(
   parameter int WIDTH = 8
) (
   input  wire logic             mclk_i,
   input  wire logic             nrst_i,
   input  wire logic             wr_i,
   input  wire logic [WIDTH-1:0] data_i,
   output logic      [WIDTH-1:0] data_o
);
   import mode_reg_pkg::*;
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) data_o <= WIDTH'(VENDOR_RESET);
      else if (wr_i) data_o <= data_i;
   end
endmodule : vendor_loc

//--- verilog/mode_reg_four_five_decode.sv
`timescale 1ns/10ps
module mode_reg_four_five_decode #(
   parameter int DATA_W = 8
) (
   input  wire logic              mclk_i,
   input  wire logic              nrst_i,
   input  wire logic              mrs_cmd_i,
   input  wire logic              mpr_wr_i,
   input  wire logic              mpr_rd_i,
   input  wire logic              bank_group1_i,
   input  wire logic              bank_group0_i,
   input  wire logic [1:0]        bank_addr_i,
   input  wire logic [13:0]       addr_i,
   input  wire logic [DATA_W-1:0] mpr_wdata_i,
   output logic      [DATA_W-1:0] mpr_rdata_o,
   output logic                   mpr_rvalid_o,
   output logic                   page_access_o,
   output logic                   preamble_training_o,
   output logic                   vref_monitor_o,
   output logic                   data_mask_o,
   output logic      [2:0]        park_termination_o,
   output logic                   term_buf_off_pd_o
);
   import mode_reg_pkg::*;

   initial begin
      if (DATA_W != 8) $error("vendor page locations are 8 bits wide");
   end

   // ************************************************
   // command decode
   // ************************************************
   wire logic [2:0] sel       = {bank_group0_i, bank_addr_i};
   wire logic       ctl_word  = (sel == SEL_CONTROL_WORD);
   wire logic       accepted  = mrs_cmd_i && !ctl_word;
   wire logic       wr_mr3    = accepted && (sel == SEL_PAGE_ACCESS);
   wire logic       wr_mr4    = accepted && (sel == SEL_PREAMBLE);
   wire logic       wr_mr5    = accepted && (sel == SEL_TERMINATION);

   logic       page_en;
   logic [1:0] page_sel;
   wire logic  vendor_page = page_en && (page_sel == PAGE_VENDOR);

   // ************************************************
   // mode register fields
   // ************************************************
   // unsupported bits are never stored, so their features stay off
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         page_en             <= 1'b0;
         page_sel            <= 2'h0;
         preamble_training_o <= 1'b0;
         vref_monitor_o      <= 1'b0;
         data_mask_o         <= 1'b0;
         park_termination_o  <= PARK_RESET;
         term_buf_off_pd_o   <= 1'b0;
      end else begin
         if (wr_mr3) begin
            page_en  <= addr_i[BIT_PAGE_EN];
            page_sel <= addr_i[1:0];
         end
         if (wr_mr4) begin
            preamble_training_o <= addr_i[BIT_TRAINING];
            vref_monitor_o      <= addr_i[BIT_MONITOR];
         end
         if (wr_mr5) begin
            data_mask_o        <= addr_i[BIT_DATA_MASK];
            park_termination_o <= addr_i[PARK_MSB:PARK_LSB];
            term_buf_off_pd_o  <= addr_i[BIT_BUF_OFF];
         end
      end
   end

   assign page_access_o = page_en;

   // ************************************************
   // vendor page locations
   // ************************************************
   logic [DATA_W-1:0] loc_q [PAGE_LOCS];
   genvar g;
   generate
      for (g = 0; g < PAGE_LOCS; g++) begin : g_loc
         wire logic hit = mpr_wr_i && vendor_page && (bank_addr_i == 2'(g));
         vendor_loc #(.WIDTH(DATA_W)) u_loc (
            .mclk_i (mclk_i),
            .nrst_i (nrst_i),
            .wr_i   (hit),
            .data_i (mpr_wdata_i),
            .data_o (loc_q[g])
         );
      end
   endgenerate

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mpr_rdata_o  <= '0;
         mpr_rvalid_o <= 1'b0;
      end else begin
         mpr_rvalid_o <= mpr_rd_i && vendor_page;
         if (mpr_rd_i && vendor_page) mpr_rdata_o <= loc_q[bank_addr_i];
      end
   end
endmodule : mode_reg_four_five_decode

//--- dv/mode_reg_checker.sv
`timescale 1ns/10ps
module mode_reg_checker (
   input wire logic        mclk_i,
   input wire logic        nrst_i,
   input wire logic        mrs_cmd_i,
   input wire logic        bank_group0_i,
   input wire logic [1:0]  bank_addr_i,
   input wire logic [13:0] addr_i,
   input wire logic        preamble_training_o,
   input wire logic        data_mask_o,
   input wire logic [2:0]  park_termination_o,
   input wire logic        term_buf_off_pd_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   wire logic [2:0] sel = {bank_group0_i, bank_addr_i};
   wire logic       w4  = mrs_cmd_i && sel == 3'h4;
   wire logic       w5  = mrs_cmd_i && sel == 3'h5;
   property p_tr; w4 |=> preamble_training_o == $past(addr_i[10]); endproperty
   a_tr: assert property (p_tr) else $error("tr");
   property p_dm; w5 |=> data_mask_o == $past(addr_i[10]); endproperty
   a_dm: assert property (p_dm) else $error("dm");
   property p_pk; w5 |=> park_termination_o == $past(addr_i[8:6]); endproperty
   a_pk: assert property (p_pk) else $error("pk");
   property p_bf; w5 |=> term_buf_off_pd_o == $past(addr_i[5]); endproperty
   a_bf: assert property (p_bf) else $error("bf");
   property p_ig; mrs_cmd_i && sel == 3'h7 |=> $stable(preamble_training_o); endproperty
   a_ig: assert property (p_ig) else $error("ig");
   property p_h5; !w5 |=> $stable(park_termination_o); endproperty
   a_h5: assert property (p_h5) else $error("h5");
   property p_h4; !w4 |=> $stable(preamble_training_o); endproperty
   a_h4: assert property (p_h4) else $error("h4");
   property p_rs; $rose(nrst_i) |-> park_termination_o == 3'h0 && !term_buf_off_pd_o; endproperty
   a_rs: assert property (p_rs) else $error("rs");
endmodule : mode_reg_checker

//--- dv/ctl_model.sv
`timescale 1ns/10ps
module ctl_model (
   input  wire logic   clk_i,
   output logic [2:0]  stb_o,
   output logic [2:0]  sel_o,
   output logic [13:0] addr_o
);
   initial {stb_o, sel_o, addr_o} = '0;
   // one strobe cycle; address scrambled once released
   task automatic issue(input logic [2:0] s, input logic [13:0] a, input logic [2:0] k);
      @(posedge clk_i) #1;
      {stb_o, sel_o, addr_o} = {k, s, a};
      @(posedge clk_i) #1;
      {stb_o, addr_o} = {3'h0, ~a};
   endtask : issue
endmodule : ctl_model

//--- dv/tb.sv
`timescale 1ns/10ps
module tb;
   logic        mclk_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        rv, tr, dm, bf, vm, pa;
   logic [2:0]  stb, sel, pk;
   logic [13:0] a;
   logic [7:0]  rd;
   int          bad_count = 0;
   int          samples_checked = 0;
   initial forever #25 mclk_i = ~mclk_i;
   ctl_model u_ctl (.clk_i(mclk_i), .stb_o(stb), .sel_o(sel), .addr_o(a));
   mode_reg_four_five_decode u_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .mrs_cmd_i(stb[2]),
      .mpr_wr_i(stb[1]), .mpr_rd_i(stb[0]), .bank_group1_i(1'b0), .bank_group0_i(sel[2]),
      .bank_addr_i(sel[1:0]), .addr_i(a), .mpr_wdata_i(a[7:0]), .mpr_rdata_o(rd),
      .mpr_rvalid_o(rv), .page_access_o(pa), .preamble_training_o(tr), .vref_monitor_o(vm),
      .data_mask_o(dm), .park_termination_o(pk), .term_buf_off_pd_o(bf));
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (6) @(posedge mclk_i);
      #1 nrst_i = 1'b1;
      chk({tr, dm, pk, bf}, 9'h000);
      for (int k = 0; k < 8; k++) begin
         u_ctl.issue(3'h5, 14'({k[0], 1'b0, k[2:0], k[1], 5'h00}), 3'h4);
         chk(9'({dm, pk, bf}), 9'({k[0], k[2:0], k[1]}));
      end
      u_ctl.issue(3'h4, 14'h0410, 3'h4);
      chk(9'({tr, pk}), 9'h00F);
      chk(9'(vm), 9'h001);
      u_ctl.issue(3'h7, 14'h0000, 3'h4);
      chk(9'({tr, dm, pk, bf}), 9'h03F);
      u_ctl.issue(3'h3, 14'h0007, 3'h4);
      chk(9'(pa), 9'h001);
      for (int k = 0; k < 8; k++) begin
         u_ctl.issue({1'b0, k[1:0]}, 14'(8'hA0 + k), k < 4 ? 3'h2 : 3'h1);
         if (k > 3) chk({rv, rd}, 9'(9'h19C + k));
      end
      print_verdict();
   end
endmodule : tb
bind mode_reg_four_five_decode mode_reg_checker u_chk (.*);
